// ===== design/ddrc_dram.sv
// DRAM end: mode registers, calibration readout and read burst path.
// Assumes the link clock and command pins arrive unsynchronised.
// Behaviour
// - Readout enabled by MR3 write, A2 high
// - Controller idles all banks before enabling
// - Reads go to pattern, not array
// - MR3 A1:A0 selects returned location
// - Only reads allowed until A2 cleared; controller still passes an MRS to any register
// - Auto precharge ignored during readout
// - Reset works while readout is enabled
// - Readout off means normal array reads
// - Line zero carries bit, others copy/zero
// - Column A1:A0 zero; other address ignored
// - A2 picks chopped half; BL8 A2=0
// - A12 selects chop on the fly
// - Beat zero is LSB, seven MSB
// - Pattern reads keep ordinary read latency
// - Controller waits for loop lock first
// - Location 00 returns alternating 0,1 pattern
// - NOP does nothing, operations continue
// - Deselect takes no command, operations continue
// - MR1 A0 high disables the loop
// - Loop-off latencies CL=6 and CWL=6
// - Loop-off read timing one cycle earlier
// - Loop-off clock period above minimum
`timescale 1ns/1ps
module ddrc_dram #(
    parameter int          ARR_DEPTH = 8,
    parameter bit          RDO_COPY  = 1'b1,
    parameter logic [63:0] ARR_SEED  = 64'h0123_4567_89AB_CDEF
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // Link
    ddrc_if.dram      lnk,
    // User-side status
    output logic      rdo_active,
    output logic      loop_off,
    output logic      rd_busy
);
    import ddrc_pkg::*;

    localparam int IW = 22;
    localparam int AW = $clog2(ARR_DEPTH);

    logic [IW-1:0] in_s1_r;
    logic [IW-1:0] in_s2_r;
    logic          ck_d_r;
    logic          ck_s;
    logic          rst_n_s;
    logic [3:0]    cmd_s;
    logic [2:0]    ba_s;
    logic [12:0]   ad_s;
    logic          rise;
    logic          fall;
    logic          rst_i;
    logic          is_mrs;
    logic          is_rd;
    logic [1:0]    bl_mode_r;
    logic [3:0]    cl_r;
    logic [1:0]    al_code_r;
    logic          dll_off_r;
    logic          rdo_en_r;
    logic [1:0]    loc_r;
    logic [3:0]    al;
    logic [4:0]    rl_w;
    logic [4:0]    lat_w;
    logic          bc4_w;
    logic [63:0]   word_w;
    logic          pend_r;
    logic          act_r;
    logic [4:0]    lat_cnt_r;
    logic [63:0]   word_r;
    logic [2:0]    sb_r;
    logic          bc4_r;
    logic [3:0]    beat_r;
    logic          tog_r;
    logic [7:0]    dq_r;
    logic          oe_r;
    logic          dqs_r;
    logic [2:0]    bidx;

    // Spread a pattern byte over eight beats, one bit per beat
    function automatic logic [63:0] rdo_word(input logic [7:0] p);
        logic [63:0] w;
        w = '0;
        for (int k = 0; k < 8; k++) begin
            w[k*8 +: 8] = {(RDO_COPY ? {7{p[k]}} : 7'h00), p[k]};
        end
        return w;
    endfunction : rdo_word

    // Array content is a fixed function of the index; no write path
    function automatic logic [63:0] arr_word(input logic [AW-1:0] i);
        return ARR_SEED ^ {8{8'(i)}};
    endfunction : arr_word

    // Two flops on every link input before any logic looks at it
    always_ff @(posedge clock) begin
        in_s1_r <= {lnk.ck, lnk.reset_n, lnk.cs_n, lnk.ras_n, lnk.cas_n,
                    lnk.we_n, lnk.ba, lnk.addr};
        in_s2_r <= in_s1_r;
        ck_d_r  <= in_s2_r[21];
    end

    // Unpack synchronised pins and find link clock edges
    assign ck_s    = in_s2_r[21];
    assign rst_n_s = in_s2_r[20];
    assign cmd_s   = in_s2_r[19:16];
    assign ba_s    = in_s2_r[15:13];
    assign ad_s    = in_s2_r[12:0];
    assign rise    = ck_s & ~ck_d_r;
    assign fall    = ~ck_s & ck_d_r;
    assign rst_i   = srst | ~rst_n_s;

    // Commands count only when selected; NOP decodes to nothing
    assign is_mrs = rise & ~cmd_s[3] & (cmd_s == CMD_MRS);
    assign is_rd  = rise & ~cmd_s[3] & (cmd_s == CMD_RD);

    // Mode registers
    always_ff @(posedge clock) begin
        if (rst_i) begin
            bl_mode_r <= BL_FIX8;
            cl_r      <= CL_RESET;
            al_code_r <= 2'h0;
            dll_off_r <= 1'b0;
            rdo_en_r  <= 1'b0;
            loc_r     <= LOC_CAL;
        end else if (is_mrs) begin
            case (ba_s)
                MR0: begin
                    bl_mode_r <= ad_s[1:0];
                    cl_r      <= 4'(ad_s[MR0_CL_LSB +: 3]) + CL_BASE;
                end
                MR1: begin
                    dll_off_r <= ad_s[MR1_DLL_BIT];
                    al_code_r <= ad_s[MR1_AL_LSB +: 2];
                end
                MR3: begin
                    rdo_en_r <= ad_s[MR3_RDO_BIT];
                    loc_r    <= ad_s[1:0];
                end
                default: ;
            endcase
        end
    end

    // Read latency; loop-off counts one cycle earlier
    always_comb begin
        case (al_code_r)
            2'h1:    al = cl_r - 4'h1;
            2'h2:    al = cl_r - 4'h2;
            default: al = 4'h0;
        endcase
        rl_w  = 5'(al) + 5'(cl_r);
        lat_w = dll_off_r ? rl_w - 5'h01 : rl_w;
    end

    // Chop choice and source word of a read being taken
    always_comb begin
        bc4_w = (bl_mode_r == BL_FIX4) |
                ((bl_mode_r == BL_OTF) & ~ad_s[BC_BIT]);
        if (rdo_en_r) begin
            // Reserved codes return all zero
            word_w = (loc_r == LOC_CAL) ? rdo_word(PATTERN_CAL) : '0;
        end else begin
            word_w = arr_word(ad_s[3 +: AW]);
        end
    end

    // Take a read and count down its latency in link cycles
    // Only one read is held; a read arriving while busy is dropped
    always_ff @(posedge clock) begin
        if (rst_i) begin
            pend_r    <= 1'b0;
            lat_cnt_r <= 5'h00;
            word_r    <= '0;
            sb_r      <= 3'h0;
            bc4_r     <= 1'b0;
        end else if (is_rd & ~pend_r & ~act_r) begin
            // Bank and A10 are not looked at, so RDA is a plain read
            pend_r    <= 1'b1;
            lat_cnt_r <= lat_w;
            word_r    <= word_w;
            sb_r      <= (bc4_w & ad_s[HALF_BIT]) ? 3'h4 : 3'h0;
            bc4_r     <= bc4_w;
        end else if (rise & pend_r) begin
            if (lat_cnt_r == 5'h01) begin
                pend_r <= 1'b0;
            end else begin
                lat_cnt_r <= lat_cnt_r - 5'h01;
            end
        end
    end

    assign bidx = sb_r + beat_r[2:0];

    // Burst out: new beat on every link edge, strobe one clock later
    // NOP and deselect do not touch a running burst
    always_ff @(posedge clock) begin
        if (rst_i) begin
            act_r  <= 1'b0;
            beat_r <= 4'h0;
            tog_r  <= 1'b0;
            dq_r   <= 8'h00;
            oe_r   <= 1'b0;
            dqs_r  <= 1'b0;
        end else begin
            tog_r <= 1'b0;
            if (tog_r) begin
                dqs_r <= ~dqs_r;
            end
            if (rise & pend_r & (lat_cnt_r == 5'h01)) begin
                act_r  <= 1'b1;
                oe_r   <= 1'b1;
                dq_r   <= word_r[{sb_r, 3'b000} +: 8];
                beat_r <= 4'h1;
                tog_r  <= 1'b1;
            end else if (act_r & (rise | fall)) begin
                if (beat_r == (bc4_r ? 4'h4 : 4'h8)) begin
                    act_r <= 1'b0;
                    oe_r  <= 1'b0;
                    dqs_r <= 1'b0;
                    dq_r  <= 8'h00;
                end else begin
                    dq_r   <= word_r[{bidx, 3'b000} +: 8];
                    beat_r <= beat_r + 4'h1;
                    tog_r  <= 1'b1;
                end
            end
        end
    end

    // Link outputs
    assign lnk.dq     = dq_r;
    assign lnk.dq_oe  = oe_r;
    assign lnk.dqs    = dqs_r;
    assign lnk.dqs_oe = oe_r;

    // User-side status
    assign rdo_active = rdo_en_r;
    assign loop_off   = dll_off_r;
    assign rd_busy    = pend_r | act_r;
endmodule : ddrc_dram

// ===== shared/ddrc_pkg.sv
// Shared constants for the calibration-readout DRAM end and its controller.
// Assumes both ends and the bench compile this package first.
package ddrc_pkg;
    // Command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_DESEL = 4'hF;
    // Mode register select on the bank address
    localparam logic [2:0] MR0 = 3'h0;
    localparam logic [2:0] MR1 = 3'h1;
    localparam logic [2:0] MR2 = 3'h2;
    localparam logic [2:0] MR3 = 3'h3;
    // Address bit positions
    localparam int MR3_RDO_BIT  = 2;
    localparam int MR1_DLL_BIT  = 0;
    localparam int MR0_CL_LSB   = 4;
    localparam int MR1_AL_LSB   = 3;
    localparam int MR2_CWL_LSB  = 3;
    localparam int AP_BIT       = 10;
    localparam int BC_BIT       = 12;
    localparam int HALF_BIT     = 2;
    // Burst length field of mode register 0
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    // Latency encodings and loop-off values
    localparam logic [3:0] CL_BASE    = 4'h4;
    localparam logic [3:0] CWL_BASE   = 4'h5;
    localparam logic [3:0] CL_RESET   = 4'h6;
    localparam logic [3:0] OFF_CL     = 4'h6;
    localparam logic [3:0] OFF_CWL    = 4'h6;
    // Calibration pattern, beat 0 in the LSB
    localparam logic [7:0] PATTERN_CAL = 8'hAA;
    localparam logic [1:0] LOC_CAL     = 2'h0;
    // Controller register byte offsets
    localparam logic [4:0] REG_CMD  = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h04;
    localparam logic [4:0] REG_RDLO = 5'h08;
    localparam logic [4:0] REG_RDHI = 5'h0C;
    localparam logic [4:0] REG_LINK = 5'h10;
    // Command register fields
    localparam int CF_BA_LSB = 13;
    localparam int CF_OP_LSB = 16;
    localparam logic [1:0] OP_MRS = 2'h0;
    localparam logic [1:0] OP_RD  = 2'h1;
    localparam logic [1:0] OP_RDA = 2'h2;
    localparam logic [1:0] OP_NOP = 2'h3;
    // Status register bits
    localparam int ST_BUSY = 0;
    localparam int ST_ERR  = 1;
    localparam int ST_RDO  = 2;
    localparam int ST_DLL  = 3;
    localparam int ST_BEAT_LSB = 4;
    // Link clock half period in system clocks
    localparam int CK_HALF_DEF = 4;
endpackage : ddrc_pkg

// ===== shared/ddrc_if.sv
// Link between the DRAM end and the controller end.
// Assumes the bench instantiates it and connects both modports.
`timescale 1ns/1ps
interface ddrc_if;
    logic        ck;
    logic        reset_n;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [12:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        dqs;
    logic        dqs_oe;
    // Controller drives clock, command and address
    modport ctrl (output ck, reset_n, cs_n, ras_n, cas_n, we_n, ba, addr,
                  input dq, dq_oe, dqs, dqs_oe);
    // DRAM end returns read data and strobe
    modport dram (input ck, reset_n, cs_n, ras_n, cas_n, we_n, ba, addr,
                  output dq, dq_oe, dqs, dqs_oe);
endinterface : ddrc_if

// ===== design/ddrc_ctrl.sv
// Controller end: Avalon-MM registers, command launch, read capture.
// Assumes software follows the mode sequence; link clock made here.
`timescale 1ns/1ps
module ddrc_ctrl #(
    parameter int CK_HALF = ddrc_pkg::CK_HALF_DEF
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Link
    ddrc_if.ctrl             lnk
);
    import ddrc_pkg::*;

    typedef enum logic [1:0] {IDLE = 2'b00, WAIT = 2'b01, HOLD = 2'b11} ddrc_st_e;

    ddrc_st_e    st_r;
    logic [7:0]  div_r;
    logic        ck_r;
    logic        tick_fall;
    logic        ack_r;
    logic        wr_go;
    logic [31:0] rdata_r;
    logic [1:0]  op;
    logic [2:0]  ba;
    logic [12:0] ad;
    logic        refuse;
    logic [12:0] ad_fix;
    logic [3:0]  pins_r;
    logic [2:0]  ba_r;
    logic [12:0] ad_r;
    logic [3:0]  cmd_nxt;
    logic        err_r;
    logic        rdo_sh_r;
    logic        dll_sh_r;
    logic [1:0]  loc_sh_r;
    logic [1:0]  bl_sh_r;
    logic        lrst_r;
    logic [8:0]  cap_s1_r;
    logic [8:0]  cap_s2_r;
    logic        dqs_d_r;
    logic [3:0]  beats_r;
    logic [63:0] rd_r;

    // Link clock divider; half period must stay above loop-off minimum
    always_ff @(posedge clock) begin
        if (srst) begin
            div_r <= 8'h00;
            ck_r  <= 1'b0;
        end else if (div_r == 8'(CK_HALF - 1)) begin
            div_r <= 8'h00;
            ck_r  <= ~ck_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    // Commands change on the falling link edge, centred on the rise
    assign tick_fall = (div_r == 8'(CK_HALF - 1)) & ck_r;

    // One wait state on every bus access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end
    assign wr_go = avs_write & ack_r;

    // Decode and police a command written by software
    assign op = avs_writedata[CF_OP_LSB +: 2];
    assign ba = avs_writedata[CF_BA_LSB +: 3];
    assign ad = avs_writedata[12:0];
    always_comb begin
        ad_fix = ad;
        refuse = (st_r != IDLE);
        // Only MRS, reads and NOP can be issued, so readout needs no more refusals
        if ((op == OP_RD) | (op == OP_RDA)) begin
            ad_fix[AP_BIT] = (op == OP_RDA);
            if (rdo_sh_r) begin
                ad_fix[1:0] = 2'h0;
                if (bl_sh_r == BL_FIX8) begin
                    ad_fix[HALF_BIT] = 1'b0;
                end
                refuse = refuse | (loc_sh_r != LOC_CAL);
                // Readout reads need a locked loop
                refuse = refuse | dll_sh_r;
            end
        end
        if ((op == OP_MRS) & dll_sh_r & (ba == MR0)) begin
            ad_fix[MR0_CL_LSB +: 3] = 3'(OFF_CL - CL_BASE);
        end
        if ((op == OP_MRS) & dll_sh_r & (ba == MR2)) begin
            ad_fix[MR2_CWL_LSB +: 3] = 3'(OFF_CWL - CWL_BASE);
        end
        case (op)
            // No activate is ever issued, so every bank is idle at an MRS
            OP_MRS:  cmd_nxt = CMD_MRS;
            OP_NOP:  cmd_nxt = CMD_NOP;
            default: cmd_nxt = CMD_RD;
        endcase
    end

    // Launch state machine and mode shadows
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r     <= IDLE;
            pins_r   <= CMD_DESEL;
            ba_r     <= 3'h0;
            ad_r     <= 13'h0000;
            rdo_sh_r <= 1'b0;
            dll_sh_r <= 1'b0;
            loc_sh_r <= LOC_CAL;
            bl_sh_r  <= BL_FIX8;
        end else begin
            unique case (st_r)
                IDLE: if (wr_go & (avs_address == REG_CMD) & ~refuse) begin
                    st_r <= WAIT;
                    ba_r <= ba;
                    ad_r <= ad_fix;
                    pins_r <= cmd_nxt;
                    if ((op == OP_MRS) & (ba == MR3)) begin
                        rdo_sh_r <= ad[MR3_RDO_BIT];
                        loc_sh_r <= ad[1:0];
                    end
                    if ((op == OP_MRS) & (ba == MR1)) begin
                        dll_sh_r <= ad[MR1_DLL_BIT];
                    end
                    if ((op == OP_MRS) & (ba == MR0)) begin
                        bl_sh_r <= ad[1:0];
                    end
                end
                WAIT: if (tick_fall) begin
                    st_r <= HOLD;
                end
                HOLD: if (tick_fall) begin
                    st_r   <= IDLE;
                    pins_r <= CMD_DESEL;
                end
            endcase
        end
    end

    // Error flag: a refused command wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            err_r <= 1'b0;
        end else if (wr_go & (avs_address == REG_CMD) & refuse) begin
            err_r <= 1'b1;
        end else if (wr_go & (avs_address == REG_STAT) & avs_writedata[ST_ERR]) begin
            err_r <= 1'b0;
        end
    end

    // Link reset bit
    always_ff @(posedge clock) begin
        if (srst) begin
            lrst_r <= 1'b0;
        end else if (wr_go & (avs_address == REG_LINK)) begin
            lrst_r <= avs_writedata[0];
        end
    end

    // Read capture on each strobe edge, after two flops
    always_ff @(posedge clock) begin
        cap_s1_r <= {lnk.dqs, lnk.dq};
        cap_s2_r <= cap_s1_r;
        dqs_d_r  <= cap_s2_r[8];
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            beats_r <= 4'h0;
            rd_r    <= '0;
        end else if ((st_r == WAIT) & tick_fall & (pins_r == CMD_RD)) begin
            beats_r <= 4'h0;
        end else if ((cap_s2_r[8] ^ dqs_d_r) & (beats_r != 4'h8)) begin
            rd_r[{beats_r[2:0], 3'b000} +: 8] <= cap_s2_r[7:0];
            beats_r <= beats_r + 4'h1;
        end
    end

    // Read data registered in the wait cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read & ~ack_r) begin
            case (avs_address)
                REG_CMD:  rdata_r <= {11'h000, 3'(pins_r[3:1]), ba_r, ad_r[12:0], 2'h0};
                REG_STAT: rdata_r <= {24'h000000, beats_r, dll_sh_r, rdo_sh_r,
                                      err_r, (st_r != IDLE)};
                REG_RDLO: rdata_r <= rd_r[31:0];
                REG_RDHI: rdata_r <= rd_r[63:32];
                REG_LINK: rdata_r <= {31'h00000000, lrst_r};
                default:  rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_r;

    // Link outputs; pins stand one full link period
    assign lnk.ck      = ck_r;
    assign lnk.reset_n = ~lrst_r;
    assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = (st_r == HOLD) ? pins_r : CMD_DESEL;
    // Address pins move only with the command, on a falling link edge
    assign lnk.ba      = (st_r == HOLD) ? ba_r : 3'h0;
    assign lnk.addr    = (st_r == HOLD) ? ad_r : 13'h0000;
endmodule : ddrc_ctrl

// ===== test/ddrc_sva.sv
// Checker on the link between the controller end and the DRAM end.
// Assumes CK_HALF of 4 and no change of AL away from its reset value.
`timescale 1ns/1ps
module ddrc_sva
    import ddrc_pkg::*;
(
    // System side
    input wire logic        clock,
    input wire logic        srst,
    // Link
    input wire logic        ck,
    input wire logic        reset_n,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [2:0]  ba,
    input wire logic [12:0] addr,
    input wire logic [7:0]  dq,
    input wire logic        dq_oe,
    input wire logic        dqs,
    input wire logic        dqs_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [3:0] cmd;
    logic       ck_q;
    logic       ck_rise;
    logic       rdo_r;
    logic       loop_r;
    logic [7:0] since_r;
    assign cmd     = {cs_n, ras_n, cas_n, we_n};
    assign ck_rise = ck && !ck_q;
    // Mode shadows; a link reset clears them as it clears the DRAM
    always_ff @(posedge clock) begin
        ck_q <= ck;
        if (srst || !reset_n) begin
            rdo_r  <= 1'b0;
            loop_r <= 1'b0;
        end else if (ck_rise && cmd == CMD_MRS && ba == MR3) begin
            rdo_r <= addr[MR3_RDO_BIT];
        end else if (ck_rise && cmd == CMD_MRS && ba == MR1) begin
            loop_r <= addr[MR1_DLL_BIT];
        end
    end
    // Cycles since the last read on the pins, saturating so idle stays quiet
    always_ff @(posedge clock) begin
        if (srst)
            since_r <= 8'hFF;
        else if (ck_rise && cmd == CMD_RD)
            since_r <= 8'h01;
        else if (since_r != 8'hFF)
            since_r <= since_r + 8'h01;
    end
    a_strobe_pair: assert property (dq_oe == dqs_oe)
        else $error("strobe enable differs from data enable");
    a_line_copy: assert property (dq_oe && rdo_r |-> dq == {8{dq[0]}})
        else $error("upper data lines do not copy line zero");
    a_pattern_beats: assert property ($rose(dq_oe) && rdo_r |->
        !dq[0] ##4 dq[0] ##4 !dq[0] ##4 dq[0]) else $error("calibration beats wrong");
    a_strobe_lag: assert property ($rose(dq_oe) |=> $rose(dqs))
        else $error("strobe did not follow first beat");
    a_read_latency: assert property ($rose(dq_oe) |->
        (loop_r ? since_r inside {[40:47]} : since_r inside {[48:56]}))
        else $error("first beat at wrong distance from read");
    a_no_stray: assert property (dq_oe |-> since_r inside {[40:100]})
        else $error("data driven without a read");
    a_cmd_stable: assert property ($changed({cmd, ba, addr}) |-> !ck)
        else $error("command pins changed while link clock high");
    a_readout_addr: assert property (ck_rise && cmd == CMD_RD && rdo_r |->
        addr[1:0] == 2'h0) else $error("readout read with nonzero low column");
    a_loopoff_lat: assert property (ck_rise && cmd == CMD_MRS && loop_r |->
        (ba != MR0 || addr[6:4] == 3'h2) && (ba != MR2 || addr[5:3] == 3'h1))
        else $error("latency not six with loop off");
    a_dram_reset: assert property ($fell(reset_n) |-> ##5 !dq_oe)
        else $error("DRAM end kept driving in reset");
    cover property ($rose(dq_oe) && rdo_r);
    cover property ($rose(dq_oe) && loop_r);
    cover property ($fell(reset_n) && rdo_r);
endmodule : ddrc_sva

// ===== test/tb.sv
// Testbench: software on the Avalon side drives both ends through the link.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module tb;
    import ddrc_pkg::*;
    logic        clock         = 1'b0;
    logic        srst          = 1'b1;
    logic [4:0]  avs_address   = 5'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rdo_act;
    logic        dram_busy;
    logic        lp_off;
    logic [31:0] rd;
    logic [31:0] pat;
    int          failures      = 0;
    int          n_tests       = 0;
    logic [12:0] ta [4]        = '{13'h1000, 13'h1400, 13'h0000, 13'h0004};
    logic [1:0]  to [4]        = '{OP_RD, OP_RDA, OP_RD, OP_RD};
    logic [3:0]  tn [4]        = '{4'h8, 4'h8, 4'h4, 4'h4};
    always #2.5 clock = ~clock;
    ddrc_if lnk();
    ddrc_dram i_ddrc_dram (.clock(clock), .srst(srst), .lnk(lnk), .rdo_active(rdo_act),
        .loop_off(lp_off), .rd_busy(dram_busy));
    ddrc_ctrl #(.CK_HALF(4)) i_ddrc_ctrl (.clock(clock), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lnk(lnk));
    ddrc_sva i_ddrc_sva (.clock(clock), .srst(srst), .ck(lnk.ck), .reset_n(lnk.reset_n),
        .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
        .ba(lnk.ba), .addr(lnk.addr), .dq(lnk.dq), .dq_oe(lnk.dq_oe), .dqs(lnk.dqs),
        .dqs_oe(lnk.dqs_oe));
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One bus access; request held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            failures++;
            results();
        end
    endtask : acc
    // Launch a link command and poll busy under a bound
    task automatic cmd(input logic [1:0] op, input logic [2:0] b, input logic [12:0] a);
        int n;
        n = 0;
        acc(1'b1, REG_CMD, {14'h0, op, b, a});
        do begin
            acc(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rd[ST_BUSY] !== 1'b0 && n < 200);
        if (n >= 200) begin
            failures++;
            results();
        end
    endtask : cmd
    // Read burst: beat count checked, low data word left in rd
    task automatic burst(input logic [1:0] op, input logic [12:0] a, input logic [3:0] nb);
        int n;
        n = 0;
        cmd(op, 3'h0, a);
        chk("read taken", {31'h0, dram_busy}, 32'h1);
        // Launch ends long before the data; wait for the DRAM end to go idle
        while (dram_busy !== 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n >= 400) begin
            failures++;
            results();
        end
        acc(1'b0, REG_STAT, 32'h0);
        chk("beats", {28'h0, rd[7:4]}, {28'h0, nb});
        acc(1'b0, REG_RDLO, 32'h0);
    endtask : burst
    initial begin
        for (int k = 0; k < 4; k++)
            pat[8*k +: 8] = {8{PATTERN_CAL[k]}};
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        acc(1'b0, REG_STAT, 32'h0);
        chk("status reset", rd, 32'h0);
        acc(1'b1, 5'h14, 32'hFFFFFFFF);
        acc(1'b0, 5'h14, 32'h0);
        chk("unmapped", rd, 32'h0);
        burst(OP_RD, 13'h1000, 4'h8);
        chk("array read", {31'h0, rd === pat}, 32'h0);
        // On-the-fly chop, CL six, then readout on
        cmd(OP_MRS, MR0, {6'h0, 3'(CL_RESET - CL_BASE), 2'h0, BL_OTF});
        cmd(OP_MRS, MR3, 13'h0004);
        chk("readout flag", {29'h0, rd[ST_RDO], 2'h0}, 32'h4);
        chk("readout port", {31'h0, rdo_act}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            burst(to[i], ta[i], tn[i]);
            chk("pattern", rd, pat);
        end
        cmd(OP_NOP, 3'h0, 13'h0);
        chk("nop status", rd & 32'h3, 32'h0);
        // Reserved location: controller refuses the read
        cmd(OP_MRS, MR3, 13'h0005);
        cmd(OP_RD, 3'h0, 13'h1000);
        chk("refused", {30'h0, rd[ST_ERR], 1'b0}, 32'h2);
        acc(1'b1, REG_STAT, 32'h2);
        acc(1'b0, REG_STAT, 32'h0);
        chk("err clear", {30'h0, rd[ST_ERR], 1'b0}, 32'h0);
        cmd(OP_MRS, MR3, 13'h0004);
        // Link reset during readout returns the DRAM to array reads
        acc(1'b1, REG_LINK, 32'h1);
        acc(1'b0, REG_STAT, 32'h0);
        acc(1'b1, REG_LINK, 32'h0);
        chk("reset port", {31'h0, rdo_act}, 32'h0);
        burst(OP_RD, 13'h1000, 4'h8);
        chk("array after reset", {31'h0, rd === pat}, 32'h0);
        cmd(OP_MRS, MR3, 13'h0000);
        chk("readout off", {29'h0, rd[ST_RDO], 2'h0}, 32'h0);
        // Loop off: latencies forced to six, read one cycle earlier
        cmd(OP_MRS, MR1, 13'h0001);
        chk("loop off", {31'h0, lp_off}, 32'h1);
        cmd(OP_MRS, MR0, 13'h0000);
        cmd(OP_MRS, MR2, 13'h0000);
        burst(OP_RD, 13'h1000, 4'h8);
        cmd(OP_MRS, MR1, 13'h0000);
        chk("loop on", {31'h0, lp_off}, 32'h0);
        results();
    end
endmodule : tb
